// ===== lsc_light_sensor_port.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"

module lsc_light_sensor_port
    import lsc_pkg::*;
#(
    parameter int H_UNIT_CYC =
        (`LSC_H_TIME_US * `LSC_CLK_MHZ) / `LSC_INTEG_DEF_DEC,
    parameter int L_UNIT_CYC =
        (`LSC_L_TIME_US * `LSC_CLK_MHZ) / `LSC_INTEG_DEF_DEC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ref_n,
    input wire logic i_addr_sel,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_light_level,
    output logic o_sda_o,
    output logic o_sda_oe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int TMR_W = 20;
    localparam logic [TMR_W-1:0] H_LEN = TMR_W'(H_UNIT_CYC - 1);
    localparam logic [TMR_W-1:0] L_LEN = TMR_W'(L_UNIT_CYC - 1);

    lsc_pins_t pins_in;   // Raw pins
    lsc_pins_t pins_s1;   // First sync stage, read only by s2
    lsc_pins_t pins_s2;   // Settled samples
    lsc_pins_t pins_d;    // Previous settled sample, for edges
    logic rst_all;        // Core reset or reference pin low
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [6:0] my_addr;  // Address picked by the strap

    lsc_bus_st_t bus_st;
    logic [3:0] bit_cnt;  // Clock pulses seen in this byte
    logic [7:0] shreg;    // Incoming byte
    logic [7:0] tx;       // Outgoing byte, msb on the wire
    logic [15:0] rd_word; // Result snapshot for one read
    logic rw;             // Read bit of the address byte
    logic got_op;         // Opcode already taken this transfer
    logic master_ack;     // Host pulled data low at ack slot
    lsc_cmd_t cmd;        // Opcode strobe to the core

    lsc_mode_t mode;
    lsc_res_t res;
    logic [7:0] integ_time;   // Integration time register
    logic [15:0] result;      // Light result register
    logic [TMR_W-1:0] unit_tmr;
    logic [7:0] unit_cnt;     // Units integrated so far
    logic [17:0] acc;         // Running integration sum
    logic [17:0] contrib;
    logic [17:0] acc_next;
    logic [TMR_W-1:0] unit_len;
    logic active;
    logic unit_done;
    logic meas_done;
    logic op_meas;
    logic op_hi;
    logic op_lo;
    logic op_known;

    // ------------------------------------------------------------
    // Pin synchronisers and bus event detection
    // ------------------------------------------------------------
    assign pins_in = {i_ref_n, i_addr_sel, i_scl, i_sda};

    // Two stages for every pin; idle bus levels at reset
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pins_s1 <= 4'hf;
            pins_s2 <= 4'hf;
            pins_d <= 4'hf;
        end else begin
            pins_s1 <= pins_in;
            pins_s2 <= pins_s1;
            pins_d <= pins_s2;
        end
    end

    // Reference pin acts as reset after sync; not filtered, one sampled low resets, 20 ns late
    assign rst_all = i_rst | ~pins_s2.ref_n;
    assign scl_rise = pins_s2.scl & ~pins_d.scl;
    assign scl_fall = ~pins_s2.scl & pins_d.scl;
    assign start_det = pins_s2.scl & pins_d.scl & pins_d.sda & ~pins_s2.sda;
    assign stop_det = pins_s2.scl & pins_d.scl & ~pins_d.sda & pins_s2.sda;
    assign my_addr = pins_s2.addr_sel ? `LSC_ADDR_HI : `LSC_ADDR_LO;

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    // Data only ever pulled low, so the output level is a fixed zero
    always_ff @(posedge i_core_clk) begin
        o_sda_o <= 1'b0;
    end

    // Bit engine; data changes on the falling clock only
    always_ff @(posedge i_core_clk) begin
        cmd.valid <= 1'b0;
        if (rst_all) begin
            bus_st <= BUS_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            rd_word <= 16'h0000;
            rw <= 1'b0;
            got_op <= 1'b0;
            master_ack <= 1'b0;
            o_sda_oe <= 1'b0;
            cmd.op <= 8'h00;
        end else if (stop_det) begin
            // Stop frees the bus from any state
            bus_st <= BUS_IDLE;
            o_sda_oe <= 1'b0;
        end else if (start_det) begin
            // Start or repeated start
            bus_st <= BUS_ADDR;
            bit_cnt <= 4'h0;
            got_op <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            if (scl_rise) begin
                shreg <= {shreg[6:0], pins_s2.sda};
                bit_cnt <= bit_cnt + 4'h1;
                master_ack <= ~pins_s2.sda;
            end
            if (scl_fall) begin
                unique case (bus_st)
                    BUS_IDLE, BUS_IGNORE: begin
                        // Wait for start or stop
                    end
                    BUS_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == my_addr) begin
                                o_sda_oe <= 1'b1;
                                rw <= shreg[0];
                                bus_st <= BUS_ADDR_ACK;
                            end else begin
                                bus_st <= BUS_IGNORE;
                            end
                        end
                    end
                    BUS_ADDR_ACK: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            // Snapshot keeps both bytes coherent
                            rd_word <= result;
                            tx <= result[15:8];
                            o_sda_oe <= ~result[15];
                            bus_st <= BUS_RD;
                        end else begin
                            o_sda_oe <= 1'b0;
                            bus_st <= BUS_WR;
                        end
                    end
                    BUS_WR: begin
                        if (bit_cnt == 4'h8) begin
                            if (!got_op) begin
                                o_sda_oe <= 1'b1;
                                got_op <= 1'b1;
                                cmd.valid <= 1'b1;
                                cmd.op <= shreg;
                                bus_st <= BUS_WR_ACK;
                            end else begin
                                // Second opcode before stop or repeated start is refused
                                bus_st <= BUS_IGNORE;
                            end
                        end
                    end
                    BUS_WR_ACK: begin
                        o_sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        bus_st <= BUS_WR;
                    end
                    BUS_RD: begin
                        if (bit_cnt == 4'h8) begin
                            o_sda_oe <= 1'b0;
                            bus_st <= BUS_RD_ACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            o_sda_oe <= ~tx[6];
                        end
                    end
                    BUS_RD_ACK: begin
                        if (master_ack) begin
                            // Next byte is the other half: low after high, high after low
                            bit_cnt <= 4'h0;
                            rd_word <= {rd_word[7:0], rd_word[15:8]};
                            tx <= rd_word[7:0];
                            o_sda_oe <= ~rd_word[7];
                            bus_st <= BUS_RD;
                        end else begin
                            bus_st <= BUS_IGNORE;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    assign op_meas = (cmd.op[7:4] == `LSC_OP_CONT_GRP ||
                      cmd.op[7:4] == `LSC_OP_ONCE_GRP) &&
                     (cmd.op[3:0] == `LSC_RES_CODE_ONE ||
                      cmd.op[3:0] == `LSC_RES_CODE_HALF ||
                      cmd.op[3:0] == `LSC_RES_CODE_FOUR);
    assign op_hi = cmd.op[7:3] == `LSC_OP_HI_TAG;
    assign op_lo = cmd.op[7:5] == `LSC_OP_LO_TAG;
    assign op_known = op_meas | op_hi | op_lo |
                      cmd.op == `LSC_OP_DOWN | cmd.op == `LSC_OP_ON |
                      cmd.op == `LSC_OP_CLEAR;

    // ------------------------------------------------------------
    // Integration timing
    // ------------------------------------------------------------
    // Conversion is integ_time units long in every mode
    assign unit_len = (res == RES_FOUR) ? L_LEN : H_LEN;
    assign active = (mode == MD_CONT) || (mode == MD_ONCE);
    assign unit_done = active && (unit_tmr == unit_len);
    assign meas_done = unit_done &&
                       ({1'b0, unit_cnt} + 9'h001 == {1'b0, integ_time});
    assign acc_next = acc + contrib;

    // Light per unit; half-lux counts twice, coarse mode a quarter
    always_comb begin
        unique case (res)
            RES_ONE: contrib = {10'h000, i_light_level};
            RES_HALF: contrib = {9'h000, i_light_level, 1'b0};
            RES_FOUR: contrib = {12'h000, i_light_level[7:2]};
            default: contrib = 18'h00000;
        endcase
    end

    // ------------------------------------------------------------
    // Mode, integration register and result
    // ------------------------------------------------------------
    // A command in the same cycle as a unit end wins; only a measurement command restarts the unit
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            mode <= MD_DOWN;
            res <= RES_ONE;
            integ_time <= `LSC_INTEG_RST;
            result <= `LSC_RESULT_RST;
            unit_tmr <= '0;
            unit_cnt <= 8'h00;
            acc <= 18'h00000;
        end else if (cmd.valid) begin
            if (cmd.op == `LSC_OP_DOWN) begin
                mode <= MD_DOWN;
            end else if (cmd.op == `LSC_OP_ON) begin
                mode <= MD_IDLE;
            end else if (cmd.op == `LSC_OP_CLEAR) begin
                if (mode != MD_DOWN) begin
                    result <= `LSC_RESULT_RST;
                end
            end else if (op_meas) begin
                mode <= (cmd.op[7:4] == `LSC_OP_CONT_GRP) ?
                        MD_CONT : MD_ONCE;
                res <= (cmd.op[3:0] == `LSC_RES_CODE_FOUR) ? RES_FOUR :
                       (cmd.op[3:0] == `LSC_RES_CODE_HALF) ? RES_HALF :
                       RES_ONE;
                unit_tmr <= '0;
                unit_cnt <= 8'h00;
                acc <= 18'h00000;
            end else if (op_hi) begin
                integ_time[7:5] <= cmd.op[2:0];
            end else if (op_lo) begin
                integ_time[4:0] <= cmd.op[4:0];
            end
            // Any other code falls through unchanged
        end else if (unit_done) begin
            unit_tmr <= '0;
            if (meas_done) begin
                // Sum over integ_time units scales count and time
                result <= (|acc_next[17:16]) ? 16'hffff : acc_next[15:0];
                acc <= 18'h00000;
                unit_cnt <= 8'h00;
                if (mode == MD_ONCE) begin
                    mode <= MD_DOWN;
                end
            end else begin
                acc <= acc_next;
                unit_cnt <= unit_cnt + 8'h01;
            end
        end else if (active) begin
            unit_tmr <= unit_tmr + TMR_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_byte_end;
        scl_fall && bit_cnt == 4'h8;
    endsequence

    sequence s_addr_hit;
        bus_st == BUS_ADDR && !rst_all ##0 s_byte_end ##0
        shreg[7:1] == my_addr;
    endsequence

    a_once_power_down: assert property (
        !rst_all && !cmd.valid && meas_done && mode == MD_ONCE
        |=> mode == MD_DOWN)
        else $error("one-shot did not power down");

    a_down_holds_result: assert property (
        !rst_all && mode == MD_DOWN && !cmd.valid
        |=> result == $past(result) && mode == MD_DOWN)
        else $error("result changed while powered down");

    a_ref_reset: assert property (
        !pins_s2.ref_n |=> mode == MD_DOWN && integ_time == 8'h45 &&
        result == 16'h0000 && !o_sda_oe)
        else $error("reference pin did not reset state");

    a_addr_ack: assert property (
        s_addr_hit |=> o_sda_oe && bus_st == BUS_ADDR_ACK)
        else $error("own address not acknowledged");

    a_addr_miss: assert property (
        bus_st == BUS_ADDR && !rst_all ##0 s_byte_end ##0
        shreg[7:1] != my_addr |=> !o_sda_oe && bus_st == BUS_IGNORE)
        else $error("foreign address acknowledged");

    a_one_opcode: assert property (
        bus_st == BUS_WR && got_op && !rst_all ##0 s_byte_end
        |=> !o_sda_oe && !cmd.valid)
        else $error("second opcode accepted");

    a_high_first: assert property (
        !rst_all && bus_st == BUS_ADDR_ACK && rw && scl_fall &&
        !start_det && !stop_det
        |=> tx == $past(result[15:8]) && bus_st == BUS_RD)
        else $error("read did not start with high byte");

    a_integ_high: assert property (
        !rst_all && cmd.valid && op_hi |=> integ_time[7:5] ==
        $past(cmd.op[2:0]) && integ_time[4:0] == $past(integ_time[4:0]))
        else $error("high integration bits wrong");

    a_integ_low: assert property (
        !rst_all && cmd.valid && op_lo |=> integ_time[4:0] ==
        $past(cmd.op[4:0]) && integ_time[7:5] == $past(integ_time[7:5]))
        else $error("low integration bits wrong");

    // Cycle count kept apart from the unit counters, so a wrong
    // unit or end count shows up against the plain product
    logic [27:0] conv_cyc;   // Cycles since the conversion began
    logic conv_clean;        // No other command since it began

    // Restarts with each command and each result
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            conv_cyc <= 28'h0000000;
            conv_clean <= 1'b0;
        end else if (cmd.valid) begin
            // Other commands may shift the units; stop judging
            conv_cyc <= 28'h0000000;
            conv_clean <= op_meas;
        end else if (meas_done) begin
            conv_cyc <= 28'h0000000;
        end else begin
            conv_cyc <= conv_cyc + 28'h0000001;
        end
    end

    a_meas_length: assert property (
        !rst_all && conv_clean && meas_done |-> conv_cyc ==
        28'(integ_time) * (28'(unit_len) + 28'h0000001) - 28'h0000001)
        else $error("conversion length not integ_time units");

    a_clear_guard: assert property (
        !rst_all && cmd.valid && cmd.op == 8'h07 && mode == MD_DOWN
        |=> result == $past(result))
        else $error("clear acted in power-down");

    a_unknown_op: assert property (
        !rst_all && cmd.valid && !op_known |=> mode == $past(mode) &&
        integ_time == $past(integ_time) && result == $past(result))
        else $error("unknown opcode changed state");

endmodule

// ===== lsc_regs.svh
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH

// ----------------------------------------------------------------
// Slave addresses chosen by the strap pin
// ----------------------------------------------------------------
`define LSC_ADDR_HI 7'h5c
`define LSC_ADDR_LO 7'h23

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSC_INTEG_RST 8'h45
`define LSC_RESULT_RST 16'h0000
`define LSC_INTEG_DEF_DEC 69

// ----------------------------------------------------------------
// Opcodes and opcode fields
// ----------------------------------------------------------------
`define LSC_OP_DOWN 8'h00
`define LSC_OP_ON 8'h01
`define LSC_OP_CLEAR 8'h07
`define LSC_OP_CONT_GRP 4'h1
`define LSC_OP_ONCE_GRP 4'h2
`define LSC_RES_CODE_ONE 4'h0
`define LSC_RES_CODE_HALF 4'h1
`define LSC_RES_CODE_FOUR 4'h3
`define LSC_OP_HI_TAG 5'h08
`define LSC_OP_LO_TAG 3'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LSC_CLK_MHZ 100
`define LSC_H_TIME_US 120000
`define LSC_L_TIME_US 16000

`endif

// ===== lsc_pkg.sv
package lsc_pkg;

    // ------------------------------------------------------------
    // Serial bus states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ADDR_ACK = 3'b010,
        BUS_WR = 3'b011,
        BUS_WR_ACK = 3'b100,
        BUS_RD = 3'b101,
        BUS_RD_ACK = 3'b110,
        BUS_IGNORE = 3'b111
    } lsc_bus_st_t;

    // ------------------------------------------------------------
    // Operating modes and resolutions
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MD_DOWN = 2'b00,
        MD_IDLE = 2'b01,
        MD_CONT = 2'b10,
        MD_ONCE = 2'b11
    } lsc_mode_t;

    typedef enum logic [1:0] {
        RES_ONE = 2'b00,
        RES_HALF = 2'b01,
        RES_FOUR = 2'b10
    } lsc_res_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic ref_n;
        logic addr_sel;
        logic scl;
        logic sda;
    } lsc_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] op;
    } lsc_cmd_t;

endpackage

// ===== lsc_i2c_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master model: open drain data, clock parked high
// ------------------------------------------------------------
module lsc_i2c_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // Idle bus, both lines released to the pull-ups
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // Quarter of the 160 ns bus period, moved on falling core edges
    task automatic q();
        repeat (4) @(negedge i_clk);
    endtask

    // One bit; sampled late in the high phase, after slave settles
    task automatic bit_x(input logic b, output logic s);
        o_sda = b;
        q();
        o_scl = 1'b1;
        q();
        q();
        s = i_sda;
        o_scl = 1'b0;
        q();
    endtask

    task automatic start();
        o_sda = 1'b0;
        q();
        q();
        o_scl = 1'b0;
        q();
    endtask

    // Clock stands high after this, outside any frame
    task automatic stop();
        o_sda = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda = 1'b1;
        q();
        q();
    endtask

    // Eight data bits then the ninth acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
            r[i] = s;
        end
        bit_x(mack, ack);
    endtask

    // One opcode per frame; a second only when a test asks for it
    task automatic send_op(input logic [6:0] a, input logic [7:0] op,
                           input logic two, input logic [7:0] op2,
                           output logic ok);
        logic [7:0] r;
        logic k1;
        logic k2;
        start();
        xfer({a, 1'b0}, 1'b1, r, k1);
        xfer(op, 1'b1, r, k2);
        if (two) begin
            xfer(op2, 1'b1, r, k2);
        end
        stop();
        ok = !k1 && !k2;
    endtask

    // High byte acked, low byte refused, then stop
    task automatic read_res(input logic [6:0] a, output logic [15:0] v,
                            output logic ok);
        logic k1;
        logic k2;
        start();
        xfer({a, 1'b1}, 1'b1, v[15:8], k1);
        xfer(8'hff, 1'b0, v[15:8], k2);
        xfer(8'hff, 1'b1, v[7:0], k2);
        stop();
        ok = !k1;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ref_n = 1'b0; // Reference pin, held low at power-up
    logic asel = 1'b0;
    logic [7:0] light = 8'h09;
    logic sda_o;
    logic sda_oe;
    logic scl;
    logic m_sda;
    logic [6:0] adr;
    int mismatches = 0;
    int n_compared = 0;
    // Wired data line: device pulls low, else master level
    wire sda = sda_oe ? sda_o : m_sda;

    always #5 clk = ~clk;

    // Short units keep a default integration of 69 units at 552 cycles
    lsc_light_sensor_port #(.H_UNIT_CYC(8), .L_UNIT_CYC(4))
        i_lsc_light_sensor_port (.i_core_clk(clk), .i_rst(rst),
        .i_ref_n(ref_n), .i_addr_sel(asel), .i_scl(scl), .i_sda(sda),
        .i_light_level(light), .o_sda_o(sda_o), .o_sda_oe(sda_oe));
    lsc_i2c_host i_lsc_i2c_host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda(m_sda));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic op(input logic [7:0] o);
        logic ok;
        i_lsc_i2c_host.send_op(adr, o, 1'b0, 8'h00, ok);
        chk(ok, 1'b1);
    endtask

    task automatic rd(input logic [15:0] exp);
        logic [15:0] v;
        logic ok;
        i_lsc_i2c_host.read_res(adr, v, ok);
        chk(ok, 1'b1);
        chk(v, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_start();
        logic [15:0] v;
        logic ok;
        adr = `LSC_ADDR_LO;
        rd(16'h0000);
        i_lsc_i2c_host.read_res(`LSC_ADDR_HI, v, ok);
        chk(ok, 1'b0);
        $display("test start done");
    endtask

    // Default integration of 69 units, 1 lx, count 69 * level
    task automatic t_once();
        op(8'h20);
        rd(16'h0000);
        cyc(600);
        rd(16'd621);
        light = 8'h03;
        cyc(700);
        rd(16'd621);
        op(8'h20);
        cyc(700);
        rd(16'd207);
        $display("test once done");
    endtask

    // Register doubled to 138: twice the count, twice the wait
    task automatic t_integ();
        light = 8'h09;
        op(8'h44);
        op(8'h6a);
        op(8'h10);
        cyc(800);
        rd(16'd207);
        rd(16'd1242);
        op(8'h11);
        cyc(1200);
        rd(16'd2484);
        op(8'h23);
        cyc(700);
        rd(16'd276);
        $display("test integ done");
    endtask

    // Clear is refused while down; odd codes and extra bytes do nothing
    task automatic t_clear();
        logic ok;
        op(8'h00);
        op(8'h07);
        rd(16'd276);
        op(8'h01);
        op(8'h07);
        rd(16'h0000);
        op(8'h55);
        i_lsc_i2c_host.send_op(adr, 8'h01, 1'b1, 8'h10, ok);
        chk(ok, 1'b0);
        cyc(1200);
        rd(16'h0000);
        $display("test clear done");
    endtask

    // Pin reset mid-measurement, then the other strap address
    task automatic t_ref();
        op(8'h10);
        cyc(1200);
        asel = 1'b1;
        ref_n = 1'b0;
        cyc(120);
        ref_n = 1'b1;
        cyc(10);
        adr = `LSC_ADDR_HI;
        cyc(1200);
        rd(16'h0000);
        op(8'h20);
        cyc(600);
        rd(16'd621);
        $display("test ref done");
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence; pin held low well beyond the required microsecond
    initial begin
        cyc(5);
        rst = 1'b0;
        cyc(120);
        ref_n = 1'b1;
        cyc(10);
        t_start();
        t_once();
        t_integ();
        t_clear();
        t_ref();
        close_out();
    end

    // Whole run needs about 21000 cycles
    initial begin
        cyc(60000);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule
